// *** design/scss_pkg.sv ***
// Purpose: Shared constants and types for the safety card state supervisor
// Assumes: 20 MHz system clock, 32-bit register port
// Notes: Times are kept in their own unit; cycle counts are derived from them
package scss_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
   localparam int unsigned CLK_PER_MS = CLK_HZ / 1_000;
   // Least low time on stop-request or reset pin, microseconds
   localparam int unsigned STOP_HOLD_US = 2000;
   localparam int unsigned STOP_HOLD_CYC = STOP_HOLD_US * CLK_PER_US;
   // Startup run-up time, milliseconds
   localparam int unsigned RUNUP_MS = 2000;
   localparam int unsigned RUNUP_CYC = RUNUP_MS * CLK_PER_MS;
   // Half period of a flashing indicator, milliseconds
   localparam int unsigned FLASH_MS = 250;
   localparam int unsigned FLASH_CYC = FLASH_MS * CLK_PER_MS;
   // Longest tolerated disagreement between the two input channels, microseconds
   localparam int unsigned DISC_US = 1000;
   localparam int unsigned DISC_CYC = DISC_US * CLK_PER_US;
   localparam int unsigned SAFE_IN_N = 9;
   localparam int unsigned STACK_DEPTH = 16;
   // Register offsets (byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_ERR_CNT = 8'h08;
   localparam logic [7:0] REG_ERR_IDX = 8'h0C;
   localparam logic [7:0] REG_ERR_DATA = 8'h10;
   // Control register bit positions (write-one pulses)
   localparam int unsigned CTRL_CFG_DEMAND = 0;
   localparam int unsigned CTRL_CARD_RESET = 1;
   localparam int unsigned CTRL_STACK_CLR = 2;
   // Status register field positions
   localparam int unsigned ST_STATE_LSB = 0;
   localparam int unsigned ST_ERR = 4;
   localparam int unsigned ST_CFG_VALID = 5;
   localparam int unsigned ST_SS1_TRIG = 6;
   localparam int unsigned ST_STOPPED = 7;
   // Reset values
   localparam logic CFG_VALID_RST = 1'b1;
   localparam logic PWR_FLAG_RST = 1'b1;
   // Error stack entry codes
   localparam logic [7:0] EV_DISC_ERR = 8'h01;
   localparam logic [7:0] EV_PD_FAIL = 8'h02;
   localparam logic [7:0] EV_CFG_BAD = 8'h03;
   localparam logic [7:0] EV_STOP_REQ = 8'h10;
   localparam logic [7:0] EV_SS1_ENTER = 8'h11;
   localparam logic [7:0] EV_SAFE_EDGE = 8'h20;

   typedef enum logic [2:0] {
      ST_PWR_ON, ST_TORQUE_OFF, ST_CONFIG, ST_STARTUP, ST_NORMAL, ST_SAFE_OP, ST_STOP_RAMP
   } scss_state_t;

   // Status from the host drive logic, same clock domain
   typedef struct packed {
      logic cfg_done;
      logic cfg_bad;
      logic sf_active;
      logic limit_violation;
      logic stop_demand;
      logic ext_error;
      logic standstill;
   } scss_host_in_t;

   // Front indicators
   typedef struct packed {
      logic run;
      logic cfg;
      logic torque_off;
   } scss_led_t;
endpackage

// *** design/scss_supervisor.sv ***
// Purpose: Operating-state supervisor of a motor-drive safety card
// Assumes: Stop-request, reset, safe inputs and disabler feedback are asynchronous pins
// Notes: Long counts are parameters so that simulation can shorten them
`timescale 1ns/1ns
module scss_supervisor
   import scss_pkg::*;
#(
   parameter int unsigned STOP_HOLD = STOP_HOLD_CYC,
   parameter int unsigned RUNUP = RUNUP_CYC,
   parameter int unsigned FLASH = FLASH_CYC,
   parameter int unsigned DISC = DISC_CYC,
   parameter int unsigned N_SAFE = SAFE_IN_N,
   parameter int unsigned DEPTH = STACK_DEPTH
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Pins from the machine
   input wire logic stop_request_input_n,
   input wire logic reset_in_n,
   input wire logic [N_SAFE-1:0] safe_in_a,
   input wire logic [N_SAFE-1:0] safe_in_b,
   input wire logic pd_feedback,
   // Host drive logic
   input wire scss_host_in_t host_in,
   output logic torque_off,
   output logic brake_ramp_en,
   output logic host_fault,
   output logic pd_test,
   // Indicators and feedback
   output scss_led_t led,
   output logic torque_off_feedback_output
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned HALF = RUNUP / 2;

   scss_state_t state_ff, nxt_state;
   logic [1:0] stop_sync_ff, rst_sync_ff, pdfb_sync_ff;
   logic [N_SAFE-1:0] sa_meta_ff, sa_ff, sa_old_ff, sb_meta_ff, sb_ff;
   logic [31:0] low_cnt_ff, runup_cnt_ff, flash_cnt_ff, disc_cnt_ff;
   logic stop_acc_ff, restart_pend_ff, pwr_flag_ff, cfg_valid_ff, err_ff;
   logic ss1_trig_ff, stopped_ff, blink_ff, cfg_demand_ff, soft_reset_ff;
   logic [PW-1:0] err_idx_ff, wr_ptr_ff;
   logic [7:0] err_cnt_ff;
   logic [7:0] stack_mem [DEPTH];
   logic pins_high, card_restart, disc_err, pd_fail, err_set, log_en;
   logic [7:0] log_code;

   // Two-flop synchronisers; only the second stage feeds logic
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stop_sync_ff <= 2'h0;
         rst_sync_ff <= 2'h0;
         pdfb_sync_ff <= 2'h0;
         sa_meta_ff <= '0;
         sa_ff <= '0;
         sa_old_ff <= '0;
         sb_meta_ff <= '0;
         sb_ff <= '0;
      end
      else
      begin
         stop_sync_ff <= {stop_sync_ff[0], stop_request_input_n};
         rst_sync_ff <= {rst_sync_ff[0], reset_in_n};
         pdfb_sync_ff <= {pdfb_sync_ff[0], pd_feedback};
         sa_meta_ff <= safe_in_a;
         sa_ff <= sa_meta_ff;
         sa_old_ff <= sa_ff;
         sb_meta_ff <= safe_in_b;
         sb_ff <= sb_meta_ff;
      end
   end

   assign pins_high = stop_sync_ff[1] & rst_sync_ff[1];
   // A card reset is the release of an accepted stop request or a software pulse
   assign card_restart = (stop_acc_ff & pins_high) | soft_reset_ff;

   // Low-time filter: a request counts only after the full hold time
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         low_cnt_ff <= 32'h0;
         stop_acc_ff <= 1'b0;
      end
      else if (pins_high)
      begin
         low_cnt_ff <= 32'h0;
         stop_acc_ff <= 1'b0;
      end
      else if (low_cnt_ff >= STOP_HOLD - 1)
         stop_acc_ff <= 1'b1;
      else
         low_cnt_ff <= low_cnt_ff + 32'h1;
   end

   // Channel disagreement on any safe input is an internal error after a grace time
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         disc_cnt_ff <= 32'h0;
      else if ((sa_ff == sb_ff) || state_ff == ST_PWR_ON)
         disc_cnt_ff <= 32'h0;
      else if (disc_cnt_ff < DISC)
         disc_cnt_ff <= disc_cnt_ff + 32'h1;
   end

   assign disc_err = (disc_cnt_ff == DISC - 1);
   // Disabler test: forced off in the first half, released in the second
   assign pd_fail = (state_ff == ST_STARTUP) &&
      (((runup_cnt_ff == HALF - 1) && !pdfb_sync_ff[1]) ||
       ((runup_cnt_ff == RUNUP - 1) && pdfb_sync_ff[1]));
   assign err_set = disc_err | pd_fail | (state_ff == ST_CONFIG && host_in.cfg_bad);

   // Latched internal error; a new error wins over a simultaneous restart
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         err_ff <= 1'b0;
      else if (err_set)
         err_ff <= 1'b1;
      else if (card_restart)
         err_ff <= 1'b0;
   end

   // Next state; outside power-on and torque-off the internal error is checked before anything else
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_PWR_ON:
            nxt_state = ST_TORQUE_OFF;
         ST_TORQUE_OFF:
            if (cfg_demand_ff)
               nxt_state = ST_CONFIG;
            else if ((pwr_flag_ff || restart_pend_ff) && cfg_valid_ff && !err_ff &&
                     pins_high && !stop_acc_ff)
               nxt_state = ST_STARTUP;
         ST_CONFIG:
            if (err_ff || host_in.cfg_bad)
               nxt_state = ST_TORQUE_OFF;
            else if (host_in.cfg_done)
               nxt_state = ST_NORMAL;
         ST_STARTUP:
            if (err_ff || pd_fail || stop_acc_ff)
               nxt_state = ST_TORQUE_OFF;
            else if (runup_cnt_ff == RUNUP - 1)
               nxt_state = ST_NORMAL;
         ST_NORMAL:
            if (err_ff)
               nxt_state = ST_TORQUE_OFF;
            else if (stop_acc_ff)
               nxt_state = ST_STOP_RAMP;
            else if (host_in.sf_active)
               nxt_state = ST_SAFE_OP;
         ST_SAFE_OP:
            if (err_ff)
               nxt_state = ST_TORQUE_OFF;
            else if (host_in.ext_error || host_in.limit_violation ||
                     host_in.stop_demand || stop_acc_ff)
               nxt_state = ST_STOP_RAMP;
            else if (!host_in.sf_active)
               nxt_state = ST_NORMAL;
         ST_STOP_RAMP:
            if (err_ff || host_in.standstill)
               nxt_state = ST_TORQUE_OFF;
         default:
            nxt_state = ST_TORQUE_OFF;
      endcase
   end

   // State register
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         state_ff <= ST_PWR_ON;
      else
         state_ff <= nxt_state;
   end

   // Start permissions: power-on flag, pending restart, valid configuration
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pwr_flag_ff <= PWR_FLAG_RST;
         restart_pend_ff <= 1'b0;
         cfg_valid_ff <= CFG_VALID_RST;
      end
      else
      begin
         if (nxt_state == ST_STARTUP || nxt_state == ST_CONFIG)
            pwr_flag_ff <= 1'b0;
         if (card_restart)
            restart_pend_ff <= 1'b1;
         else if (nxt_state == ST_STARTUP)
            restart_pend_ff <= 1'b0;
         if (state_ff == ST_CONFIG && host_in.cfg_bad)
            cfg_valid_ff <= 1'b0;
         else if (state_ff == ST_CONFIG && host_in.cfg_done)
            cfg_valid_ff <= 1'b1;
      end
   end

   // Controlled-stop and stopped-condition markers for the red indicator
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ss1_trig_ff <= 1'b0;
         stopped_ff <= 1'b0;
      end
      else
      begin
         if (nxt_state == ST_STOP_RAMP)
            ss1_trig_ff <= 1'b1;
         else if (card_restart)
            ss1_trig_ff <= 1'b0;
         if (state_ff == ST_STOP_RAMP && nxt_state == ST_TORQUE_OFF && stop_acc_ff)
            stopped_ff <= 1'b1;
         else if (card_restart)
            stopped_ff <= 1'b0;
      end
   end

   // Run-up counter for the startup self-test
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         runup_cnt_ff <= 32'h0;
      else if (state_ff == ST_STARTUP)
         runup_cnt_ff <= runup_cnt_ff + 32'h1;
      else
         runup_cnt_ff <= 32'h0;
   end

   // Flash divider; one toggle every half period
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         flash_cnt_ff <= 32'h0;
         blink_ff <= 1'b0;
      end
      else if (flash_cnt_ff == FLASH - 1)
      begin
         flash_cnt_ff <= 32'h0;
         blink_ff <= ~blink_ff;
      end
      else
         flash_cnt_ff <= flash_cnt_ff + 32'h1;
   end

   // Outputs follow the next state so they line up with state_ff
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         torque_off <= 1'b1;
         torque_off_feedback_output <= 1'b0;
         brake_ramp_en <= 1'b0;
         host_fault <= 1'b0;
         pd_test <= 1'b0;
      end
      else
      begin
         torque_off <= !(nxt_state inside {ST_NORMAL, ST_SAFE_OP, ST_STOP_RAMP});
         torque_off_feedback_output <= (nxt_state == ST_TORQUE_OFF);
         brake_ramp_en <= (nxt_state == ST_STOP_RAMP);
         host_fault <= err_ff | err_set;
         pd_test <= (nxt_state == ST_STARTUP) && (runup_cnt_ff < HALF - 1);
      end
   end

   // Indicators: run flashes in startup, red flashes in the stopped condition
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         led <= '0;
      else
      begin
         led.run <= (nxt_state == ST_STARTUP) ? blink_ff :
            (nxt_state inside {ST_NORMAL, ST_SAFE_OP});
         led.cfg <= (nxt_state == ST_CONFIG);
         led.torque_off <= (nxt_state != ST_TORQUE_OFF) ? 1'b0 :
            stopped_ff ? blink_ff : (err_ff | ss1_trig_ff);
      end
   end

   // Event selection for the error stack; errors first, then messages
   always_comb
   begin
      log_en = 1'b1;
      log_code = 8'h00;
      if (disc_err)
         log_code = EV_DISC_ERR;
      else if (pd_fail)
         log_code = EV_PD_FAIL;
      else if (state_ff == ST_CONFIG && host_in.cfg_bad)
         log_code = EV_CFG_BAD;
      else if (state_ff != ST_STOP_RAMP && nxt_state == ST_STOP_RAMP)
         log_code = EV_SS1_ENTER;
      else if (low_cnt_ff == STOP_HOLD - 1 && !pins_high && !stop_acc_ff)
         log_code = EV_STOP_REQ;
      else if (sa_ff != sa_old_ff)
         log_code = EV_SAFE_EDGE;
      else
         log_en = 1'b0;
   end

   // Error stack storage; it wraps and keeps the newest entries
   always_ff @(posedge sys_clk)
   begin
      if (log_en)
         stack_mem[wr_ptr_ff] <= log_code;
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_ptr_ff <= '0;
         err_cnt_ff <= 8'h00;
      end
      else if (log_en)
      begin
         wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + PW'(1);
         if (err_cnt_ff != 8'hFF)
            err_cnt_ff <= err_cnt_ff + 8'h01;
      end
      else if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_STACK_CLR])
      begin
         wr_ptr_ff <= '0;
         err_cnt_ff <= 8'h00;
      end
   end

   // Register writes; control bits are one-cycle pulses
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cfg_demand_ff <= 1'b0;
         soft_reset_ff <= 1'b0;
         err_idx_ff <= '0;
      end
      else
      begin
         cfg_demand_ff <= reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_CFG_DEMAND];
         soft_reset_ff <= reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_CARD_RESET];
         if (reg_wr && reg_addr == REG_ERR_IDX)
            err_idx_ff <= reg_wdata[PW-1:0];
      end
   end

   // Read data stands for one cycle; unmapped addresses read zero
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         reg_rdata <= 32'h0;
      else if (!reg_rd)
         reg_rdata <= 32'h0;
      else
         case (reg_addr)
            REG_STATUS:
            begin
               reg_rdata <= 32'h0;
               reg_rdata[ST_STATE_LSB +: 3] <= state_ff;
               reg_rdata[ST_ERR] <= err_ff;
               reg_rdata[ST_CFG_VALID] <= cfg_valid_ff;
               reg_rdata[ST_SS1_TRIG] <= ss1_trig_ff;
               reg_rdata[ST_STOPPED] <= stopped_ff;
            end
            REG_ERR_CNT:
               reg_rdata <= {24'h0, err_cnt_ff};
            REG_ERR_IDX:
               reg_rdata <= 32'(err_idx_ff);
            REG_ERR_DATA:
               reg_rdata <= {24'h0, stack_mem[err_idx_ff]};
            default:
               reg_rdata <= 32'h0;
         endcase
   end

   // Checks
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   sequence seq_cfg_clean;
      state_ff == ST_CONFIG && !err_ff && !host_in.cfg_bad && host_in.cfg_done;
   endsequence
   sequence seq_safe_stop_cause;
      state_ff == ST_SAFE_OP && !err_ff &&
         (host_in.ext_error || host_in.limit_violation || host_in.stop_demand);
   endsequence

   chk_power_first_off: assert property (state_ff == ST_PWR_ON |=> state_ff == ST_TORQUE_OFF)
      else $error("power-on did not enter torque-off");
   chk_cfg_ok_normal: assert property (seq_cfg_clean |=> state_ff == ST_NORMAL)
      else $error("clean configuration did not reach normal");
   chk_cfg_bad_off: assert property (state_ff == ST_CONFIG && host_in.cfg_bad
      |=> state_ff == ST_TORQUE_OFF && !cfg_valid_ff)
      else $error("bad configuration did not force torque-off");
   chk_cfg_no_power: assert property (state_ff == ST_CONFIG |-> torque_off && led.cfg)
      else $error("motor powered during configuration");
   chk_err_wins: assert property (err_ff && state_ff inside {ST_NORMAL, ST_SAFE_OP,
      ST_STOP_RAMP, ST_STARTUP} |=> state_ff == ST_TORQUE_OFF ##1 torque_off)
      else $error("internal error did not win");
   chk_safe_entry: assert property (state_ff == ST_NORMAL && !err_ff && !stop_acc_ff &&
      host_in.sf_active |=> state_ff == ST_SAFE_OP)
      else $error("active function did not enter safe operation");
   chk_stop_entry: assert property (seq_safe_stop_cause |=> state_ff == ST_STOP_RAMP
      && brake_ramp_en && !torque_off)
      else $error("controlled stop not entered");
   chk_safe_return: assert property (state_ff == ST_SAFE_OP && !err_ff && !stop_acc_ff &&
      !(host_in.ext_error || host_in.limit_violation || host_in.stop_demand) &&
      !host_in.sf_active |=> state_ff == ST_NORMAL)
      else $error("safe operation did not return to normal");
   chk_stop_hold: assert property ($rose(stop_acc_ff) |-> $past(low_cnt_ff) == STOP_HOLD - 1
      && !$past(pins_high))
      else $error("stop request taken before hold time");
   chk_feedback_off: assert property (state_ff == ST_TORQUE_OFF |-> torque_off_feedback_output
      && torque_off && !brake_ramp_en)
      else $error("feedback wrong in torque-off");
   chk_fault_report: assert property ($rose(err_ff) |-> host_fault ##1 host_fault)
      else $error("error not reported to host");
endmodule

// *** verification/scss_host_model.sv ***
// Purpose: Host drive logic model facing the state supervisor
// Assumes: Same clock as the supervisor
// Notes: Standstill follows the braking ramp after six cycles
`timescale 1ns/1ns
module scss_host_model
   import scss_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Bench requests and supervisor outputs
   input wire scss_host_in_t cmd,
   input wire logic brake_ramp_en,
   input wire logic pd_test,
   // Towards the supervisor
   output scss_host_in_t host_in,
   output logic pd_feedback
);
   logic [2:0] ramp_cnt_ff;

   // Drive needs a few cycles of ramp before it reports standstill
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
         ramp_cnt_ff <= 3'h0;
      else if (!brake_ramp_en)
         ramp_cnt_ff <= 3'h0;
      else if (ramp_cnt_ff != 3'h6)
         ramp_cnt_ff <= ramp_cnt_ff + 3'h1;

   // Disabler answers the forced test one cycle late, like a real stage
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
         pd_feedback <= 1'b0;
      else
         pd_feedback <= pd_test;

   // Bench levels pass through, standstill comes from the ramp
   always_comb
   begin
      host_in = cmd;
      host_in.standstill = (ramp_cnt_ff == 3'h6);
   end
endmodule

// *** verification/scss_supervisor_bench.sv ***
// Purpose: Self-checking bench for the state supervisor
// Assumes: Shortened counts STOP_HOLD 8, RUNUP 40, FLASH 4, DISC 6
// Notes: Read results are checked by a monitor against queued notes
`timescale 1ns/1ns
module scss_supervisor_bench;
   import scss_pkg::*;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic stop_n = 1'b1;
   logic rst_in_n = 1'b1;
   logic [8:0] sa = 9'h0;
   logic [8:0] sb = 9'h0;
   logic [8:0] r;
   logic lv;
   logic pd_fb, torque_off, brake_ramp_en, host_fault, pd_test, fb;
   scss_host_in_t cmd = '0;
   scss_host_in_t host_in;
   scss_led_t led;
   logic [63:0] notes[$];
   logic rd_pend = 1'b0;
   int failures = 0;
   int compares = 0;

   // Clock at 20 MHz
   always #25 sys_clk = ~sys_clk;

   // Channel count and stack depth stay at their defaults
   scss_supervisor #(.STOP_HOLD(8), .RUNUP(40), .FLASH(4), .DISC(6))
   u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .stop_request_input_n(stop_n), .reset_in_n(rst_in_n), .safe_in_a(sa),
      .safe_in_b(sb), .pd_feedback(pd_fb), .host_in(host_in), .torque_off(torque_off),
      .brake_ramp_en(brake_ramp_en), .host_fault(host_fault), .pd_test(pd_test),
      .led(led), .torque_off_feedback_output(fb));

   scss_host_model u_host (.sys_clk(sys_clk), .arst_n(arst_n), .cmd(cmd),
      .brake_ramp_en(brake_ramp_en), .pd_test(pd_test), .host_in(host_in),
      .pd_feedback(pd_fb));

   task automatic test_done;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk_pin(input logic got, input logic exp);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t pin %b want %b", $time, got, exp);
      end
   endtask

   task automatic chk_reg(input logic [31:0] got, input logic [63:0] note);
      compares++;
      if ((got & note[63:32]) !== note[31:0])
      begin
         failures++;
         $display("[ERR] %0t read %h want %h", $time, got, note[31:0]);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // Note first, then strobe; the monitor pops when the data stands
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      notes.push_back({m, e});
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
   endtask

   task automatic st(input logic [31:0] e);
      rd(REG_STATUS, 32'h7, e);
   endtask

   // Bounded wait on torque_off (sel 0) or brake_ramp_en (sel 1)
   task automatic wait_for(input int sel, input logic want);
      int i;
      for (i = 0; i < 300; i++)
      begin
         @(posedge sys_clk);
         #1;
         if ((sel == 0 ? torque_off : brake_ramp_en) === want)
            break;
      end
      if (i == 300)
      begin
         failures++;
         $display("[ERR] %0t wait %0d timed out", $time, sel);
      end
   endtask

   // Read data stand in the cycle after the strobe only
   always @(posedge sys_clk)
   begin
      if (rd_pend)
         chk_reg(reg_rdata, notes.pop_front());
      rd_pend <= reg_rd;
   end

   // Whole run is about 250 cycles
   initial
   begin
      cyc(5000);
      failures++;
      $display("[ERR] %0t watchdog expired", $time);
      test_done();
   end

   initial
   begin
      r = 9'($urandom(32'h988B));
      cyc(5);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk_pin(fb, 1'b1);
      chk_pin(torque_off, 1'b1);
      wait_for(0, 1'b0);
      st(32'h4);
      chk_pin(led.run, 1'b1);
      chk_pin(led.cfg, 1'b0);
      chk_pin(led.torque_off, 1'b0);
      repeat (4)
      begin
         @(posedge sys_clk);
         r = 9'($urandom);
         sa <= r;
         sb <= r;
      end
      st(32'h4);
      cmd.sf_active <= 1'b1;
      cyc(3);
      st(32'h5);
      cmd.sf_active <= 1'b0;
      cyc(3);
      st(32'h4);
      cmd.sf_active <= 1'b1;
      cyc(3);
      cmd.limit_violation <= 1'b1;
      wait_for(1, 1'b1);
      st(32'h6);
      wait_for(0, 1'b1);
      chk_pin(fb, 1'b1);
      chk_pin(led.torque_off, 1'b1);
      cmd <= '0;
      cyc(20);
      st(32'h1);
      wr(REG_CTRL, 32'h1);
      cyc(2);
      st(32'h2);
      chk_pin(torque_off, 1'b1);
      chk_pin(led.cfg, 1'b1);
      cmd.cfg_done <= 1'b1;
      wait_for(0, 1'b0);
      cmd.cfg_done <= 1'b0;
      st(32'h4);
      chk_pin(led.cfg, 1'b0);
      // Either pin low starts the stop; held well past the minimum
      @(posedge sys_clk);
      if ($urandom % 2)
         stop_n <= 1'b0;
      else
         rst_in_n <= 1'b0;
      wait_for(1, 1'b1);
      wait_for(0, 1'b1);
      // Red indicator flashes: half a period later it shows the other level
      cyc(1);
      #1;
      lv = led.torque_off;
      cyc(4);
      #1;
      chk_pin(led.torque_off, !lv);
      rd(REG_STATUS, 32'h87, 32'h81);
      stop_n <= 1'b1;
      rst_in_n <= 1'b1;
      wait_for(0, 1'b0);
      st(32'h4);
      chk_pin(led.run, 1'b1);
      cmd.sf_active <= 1'b1;
      cyc(3);
      st(32'h5);
      sb <= ~sa;
      wait_for(0, 1'b1);
      chk_pin(brake_ramp_en, 1'b0);
      chk_pin(host_fault, 1'b1);
      rd(REG_STATUS, 32'h17, 32'h11);
      sb <= sa;
      cmd <= '0;
      // Card reset clears the latched error, else configuration falls back at once
      wr(REG_CTRL, 32'h3);
      cyc(2);
      st(32'h2);
      cmd.cfg_bad <= 1'b1;
      cyc(2);
      cmd.cfg_bad <= 1'b0;
      rd(REG_STATUS, 32'h37, 32'h11);
      chk_pin(torque_off, 1'b1);
      wr(REG_ERR_IDX, 32'h5);
      rd(REG_ERR_IDX, 32'hF, 32'h5);
      // Empty the stack, then one edge on the safe inputs makes one entry
      wr(REG_CTRL, 32'h4);
      rd(REG_ERR_CNT, 32'hFF, 32'h0);
      sa <= ~sa;
      sb <= ~sb;
      cyc(6);
      rd(REG_ERR_CNT, 32'hFF, 32'h1);
      wr(REG_ERR_IDX, 32'h0);
      rd(REG_ERR_DATA, 32'hFF, 32'h20);
      rd(8'h3C, 32'hFFFFFFFF, 32'h0);
      cyc(3);
      test_done();
   end
endmodule
